// ### hdl/ioss_defines.svh
// Purpose: Selector codes, bus width and selector reset values for the operand slice selector.
// Assumes: Included by bare name; holds definitions only.
// Notes: Low selector is 5 bits, high selector is 6 bits.
`ifndef IOSS_DEFINES_SVH
`define IOSS_DEFINES_SVH
`define IOSS_BUS_W 72
`define IOSS_LO_SEL_RESET 5'h00
`define IOSS_HI_SEL_RESET 6'h00
`define IOSS_LO_I8_X1 5'h00
`define IOSS_LO_I8_X2 5'h01
`define IOSS_LO_I7_X1 5'h07
`define IOSS_LO_I7_X2 5'h08
`define IOSS_LO_I6_X1 5'h0a
`define IOSS_LO_I6_X2 5'h0b
`define IOSS_LO_I16_X1 5'h11
`define IOSS_LO_I16_X2 5'h12
`define IOSS_HI_I8_X1 6'h00
`define IOSS_HI_I8_X2 6'h01
`define IOSS_HI_I7_X1 6'h07
`define IOSS_HI_I7_X2 6'h08
`define IOSS_HI_I6_X1 6'h0a
`define IOSS_HI_I6_X2 6'h0b
`define IOSS_HI_I16_X1 6'h11
`define IOSS_HI_I16_X2 6'h12
`define IOSS_HI_I8_SPLIT 6'h20
`define IOSS_HI_I8_X4 6'h21
`define IOSS_HI_I7_SPLIT 6'h27
`define IOSS_HI_I7_X4 6'h28
`define IOSS_HI_I6_SPLIT 6'h2a
`define IOSS_HI_I6_X4 6'h2b
`define IOSS_HI_I16_SPLIT 6'h31
`define IOSS_HI_I16_COMPACT 6'h32
`endif

// ### hdl/ioss_pkg.sv
// Purpose: Types shared by the operand slice selector files.
// Assumes: Nothing is imported; users write ioss_pkg::name.
// Notes: Operand lanes are 16 bits wide; narrow operands sit in the low bits.
package ioss_pkg;
	// Four operand buses arriving from the fabric.
	typedef struct packed {
		logic [71:0] a_lo;
		logic [71:0] b_lo;
		logic [71:0] a_hi;
		logic [71:0] b_hi;
	} ioss_buses_s;
	// Sixteen operand pairs, index 0 in the low bits.
	typedef struct packed {
		logic [15:0][15:0] a;
		logic [15:0][15:0] b;
		logic [15:0] used;
	} ioss_lanes_s;
	typedef enum logic [2:0] {
		IOSS_W8,
		IOSS_W7,
		IOSS_W6,
		IOSS_W16,
		IOSS_WNONE
	} ioss_width_e;
endpackage

// ### hdl/ioss_half_route.sv
// Purpose: Cuts up to eight operands from one 72-bit bus at a given width and offset.
// Assumes: Width and start bit are fixed configuration.
// Notes: Pure combinational multiplexing.
`timescale 1ns/1ps
module ioss_half_route #(
	parameter int COUNT = 8
) (
	input wire logic [71:0] BUS,
	input wire ioss_pkg::ioss_width_e WIDTH,
	input wire logic [6:0] START,
	output logic [7:0][15:0] OPS
);
	// Each lane takes a slice at START plus its index times the width.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			OPS[i] = 16'h0000;
			if (i < COUNT) begin
				unique case (WIDTH)
					ioss_pkg::IOSS_W8: OPS[i] = {8'h00, BUS[(8 * i + START) % 72 +: 8]};
					ioss_pkg::IOSS_W7: OPS[i] = {9'h000, BUS[(7 * i + START) % 72 +: 7]};
					ioss_pkg::IOSS_W6: OPS[i] = {10'h000, BUS[(6 * i + START) % 72 +: 6]};
					ioss_pkg::IOSS_W16: OPS[i] = BUS[(16 * i + START) % 72 +: 16];
					ioss_pkg::IOSS_WNONE: OPS[i] = 16'h0000;
				endcase
			end
		end
	end
endmodule

// ### hdl/ioss_slice_select.sv
// Purpose: Routes operand slices from four 72-bit buses to sixteen multiplier lanes.
// Assumes: Selector codes are static; fabric zeroes unused bus bits.
// Notes: Outputs are registered once on CLK under CLK_EN.
`timescale 1ns/1ps
`include "ioss_defines.svh"
// Function
// [RULE_01] Six-bit single: 0x0a, low buses only
// [RULE_02] Six-bit double: 0x0b, high bits 71..48
// [RULE_03] Six-bit quad: 0x0b/0x2b, sixteen pairs
// [RULE_04] Six-bit split: 0x0a/0x2a mirrors single
// [RULE_05] Four-bit packs two into eight-bit codes
// [RULE_06] Three-bit packs two into six-bit codes
// [RULE_07] Sixteen-bit single: 0x11, low buses only
// [RULE_08] Sixteen-bit double: 0x12, high bits 63..32
// [RULE_09] Sixteen-bit split: 0x11/0x31 mirrors single
// [RULE_10] Sixteen-bit compact: 0x12/0x32, bits 31..0
// [RULE_11] Eight-bit codes 0x00, 0x01, 0x21
// [RULE_12] Seven-bit codes 0x07 and 0x08
// [RULE_13] Selectors 5 and 6 bits, default zero
// [RULE_14] Fabric zeroes unused operand bus bits
// [RULE_15] Selectors must agree with multiplier format
// [RULE_16] Static selectors, combinational slice routing
module ioss_slice_select #(
	parameter logic [4:0] LO_SEL = `IOSS_LO_SEL_RESET,
	parameter logic [5:0] HI_SEL = `IOSS_HI_SEL_RESET
) (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic CLK_EN,
	input wire ioss_pkg::ioss_buses_s BUSES,
	output ioss_pkg::ioss_lanes_s LANES,
	output logic SEL_VALID
);
	typedef struct packed {
		ioss_pkg::ioss_width_e width;
		logic [6:0] a_start;
		logic [6:0] b_start;
		logic [3:0] count;
	} ioss_cut_s;

	// Low-half layout from the low selector; four- and three-bit data ride in the same slices.
	function automatic ioss_cut_s lo_cut(input logic [4:0] sel);
		ioss_cut_s c;
		c = '{ioss_pkg::IOSS_WNONE, 7'h00, 7'h00, 4'h0};
		unique case (sel)
			`IOSS_LO_I8_X1: c = '{ioss_pkg::IOSS_W8, 7'h00, 7'h20, 4'h4}; // RULE_11 RULE_05
			`IOSS_LO_I8_X2: c = '{ioss_pkg::IOSS_W8, 7'h00, 7'h00, 4'h8}; // RULE_11 RULE_05
			`IOSS_LO_I7_X1: c = '{ioss_pkg::IOSS_W7, 7'h00, 7'h23, 4'h5}; // RULE_12
			`IOSS_LO_I7_X2: c = '{ioss_pkg::IOSS_W7, 7'h00, 7'h00, 4'h8}; // RULE_12
			`IOSS_LO_I6_X1: c = '{ioss_pkg::IOSS_W6, 7'h00, 7'h24, 4'h6}; // RULE_01 RULE_04 RULE_06
			`IOSS_LO_I6_X2: c = '{ioss_pkg::IOSS_W6, 7'h00, 7'h00, 4'h8}; // RULE_02 RULE_03 RULE_06
			`IOSS_LO_I16_X1: c = '{ioss_pkg::IOSS_W16, 7'h00, 7'h20, 4'h2}; // RULE_07 RULE_09
			`IOSS_LO_I16_X2: c = '{ioss_pkg::IOSS_W16, 7'h00, 7'h00, 4'h2}; // RULE_08 RULE_10
			default: c = '{ioss_pkg::IOSS_WNONE, 7'h00, 7'h00, 4'h0};
		endcase
		return c;
	endfunction

	// High-half layout; plain double codes fill upper bits, 0x2x/0x3x codes repeat the low layout.
	function automatic ioss_cut_s hi_cut(input logic [5:0] sel);
		ioss_cut_s c;
		c = '{ioss_pkg::IOSS_WNONE, 7'h00, 7'h00, 4'h0};
		unique case (sel)
			`IOSS_HI_I8_X2: c = '{ioss_pkg::IOSS_W8, 7'h40, 7'h40, 4'h1};
			`IOSS_HI_I7_X2: c = '{ioss_pkg::IOSS_W7, 7'h38, 7'h38, 4'h2};
			`IOSS_HI_I6_X2: c = '{ioss_pkg::IOSS_W6, 7'h30, 7'h30, 4'h4}; // RULE_02
			`IOSS_HI_I16_X2: c = '{ioss_pkg::IOSS_W16, 7'h20, 7'h20, 4'h2}; // RULE_08
			`IOSS_HI_I8_SPLIT: c = '{ioss_pkg::IOSS_W8, 7'h00, 7'h20, 4'h4};
			`IOSS_HI_I8_X4: c = '{ioss_pkg::IOSS_W8, 7'h00, 7'h00, 4'h8}; // RULE_11
			`IOSS_HI_I7_SPLIT: c = '{ioss_pkg::IOSS_W7, 7'h00, 7'h23, 4'h5};
			`IOSS_HI_I7_X4: c = '{ioss_pkg::IOSS_W7, 7'h00, 7'h00, 4'h8};
			`IOSS_HI_I6_SPLIT: c = '{ioss_pkg::IOSS_W6, 7'h00, 7'h24, 4'h6}; // RULE_04
			`IOSS_HI_I6_X4: c = '{ioss_pkg::IOSS_W6, 7'h00, 7'h00, 4'h8}; // RULE_03
			`IOSS_HI_I16_SPLIT: c = '{ioss_pkg::IOSS_W16, 7'h00, 7'h20, 4'h2}; // RULE_09
			`IOSS_HI_I16_COMPACT: c = '{ioss_pkg::IOSS_W16, 7'h00, 7'h00, 4'h2}; // RULE_10
			default: c = '{ioss_pkg::IOSS_WNONE, 7'h00, 7'h00, 4'h0};
		endcase
		return c;
	endfunction

	localparam ioss_cut_s LO = lo_cut(LO_SEL); // RULE_13 RULE_16
	localparam ioss_cut_s HI = hi_cut(HI_SEL); // RULE_16
	// Low selector codes 0x00/0x07/0x0a/0x11 pair with a single-mode high code that leaves the high bank idle.
	localparam bit HI_IDLE = (HI_SEL == `IOSS_HI_I8_X1) || (HI_SEL == `IOSS_HI_I7_X1) ||
		(HI_SEL == `IOSS_HI_I6_X1) || (HI_SEL == `IOSS_HI_I16_X1); // RULE_01 RULE_07
	// Plain double codes take the high lanes from the upper part of the high bus, after the low lanes.
	localparam bit HI_UPPER = (HI_SEL == `IOSS_HI_I8_X2) || (HI_SEL == `IOSS_HI_I7_X2) ||
		(HI_SEL == `IOSS_HI_I6_X2) || (HI_SEL == `IOSS_HI_I16_X2);
	localparam int LO_N = int'(LO.count);
	localparam int HI_N = HI_IDLE ? 0 : int'(HI.count);
	// Sixteen-bit high lanes follow the low lanes directly; narrow split and quad layouts start at lane 8.
	localparam int HI_BASE = (HI_UPPER || HI.width == ioss_pkg::IOSS_W16) ? LO_N : 8; // RULE_09 RULE_10
	// An unknown code gives no lanes in its own half and drives SEL_VALID low; known low and high codes of different widths still read valid.
	localparam bit CFG_OK = (LO.width != ioss_pkg::IOSS_WNONE) &&
		(HI_IDLE || HI.width != ioss_pkg::IOSS_WNONE);

	logic [7:0][15:0] lo_a;
	logic [7:0][15:0] lo_b;
	logic [7:0][15:0] hi_a;
	logic [7:0][15:0] hi_b;
	ioss_pkg::ioss_lanes_s lanes;
	ioss_pkg::ioss_lanes_s next_lanes;
	logic sel_valid;
	logic next_sel_valid;

	ioss_half_route #(.COUNT(8)) u_lo_a (.BUS(BUSES.a_lo), .WIDTH(LO.width), .START(LO.a_start), .OPS(lo_a));
	ioss_half_route #(.COUNT(8)) u_lo_b (.BUS(BUSES.b_lo), .WIDTH(LO.width), .START(LO.b_start), .OPS(lo_b));
	ioss_half_route #(.COUNT(8)) u_hi_a (.BUS(BUSES.a_hi), .WIDTH(HI.width), .START(HI.a_start), .OPS(hi_a));
	ioss_half_route #(.COUNT(8)) u_hi_b (.BUS(BUSES.b_hi), .WIDTH(HI.width), .START(HI.b_start), .OPS(hi_b));

	// Place low-bank operands in lanes 0 up, high-bank operands from HI_BASE up; unused lanes read zero.
	always_comb begin
		next_lanes = '0;
		for (int i = 0; i < 16; i++) begin
			if (i < LO_N) begin
				next_lanes.a[i] = lo_a[i]; // RULE_16
				next_lanes.b[i] = lo_b[i];
				next_lanes.used[i] = 1'b1;
			end else if (i >= HI_BASE && i < HI_BASE + HI_N) begin
				next_lanes.a[i] = hi_a[i - HI_BASE]; // RULE_16
				next_lanes.b[i] = hi_b[i - HI_BASE];
				next_lanes.used[i] = 1'b1;
			end
		end
		next_sel_valid = CFG_OK;
	end

	// Output register keeps every top-level output on a flip-flop; CLK_EN freezes it.
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			lanes <= '0;
			sel_valid <= 1'b0;
		end else if (CLK_EN) begin
			lanes <= next_lanes;
			sel_valid <= next_sel_valid;
		end
	end

	assign LANES = lanes;
	assign SEL_VALID = sel_valid;
endmodule

// ### verification/ioss_fabric_model.sv
// Purpose: Fabric model driving the four operand buses.
// Assumes: Only the low USED_W bits of each bus belong to the layout.
// Notes: The word changes every cycle, so a stale slice shows; each bus repeats one byte, so a shift by whole bytes does not.
`timescale 1ns/1ps
module ioss_fabric_model #(
	parameter int USED_W = 48
) (
	input wire logic CLK,
	output ioss_pkg::ioss_buses_s BUSES
);
	logic [7:0] k = 8'h00;
	logic [71:0] m;
	// Bits outside the layout stay at zero.
	assign m = (72'h1 << USED_W) - 72'h1;
	// A new word lands just after each rising edge.
	always @(posedge CLK) begin
		k <= k + 8'h01;
		BUSES.a_lo <= {9{k}} & m;
		BUSES.b_lo <= {9{~k}} & m;
		BUSES.a_hi <= {9{k ^ 8'h5a}} & m;
		BUSES.b_hi <= {9{k + 8'h33}} & m;
	end
endmodule

// ### verification/ioss_slice_select_props.sv
// Purpose: Routing and timing properties of the slice selector.
// Assumes: Bound to each instance with its selector codes.
// Notes: Routing checks cover the six-bit quad and sixteen-bit compact codes.
`timescale 1ns/1ps
module ioss_slice_select_props #(
	parameter logic [4:0] LO_SEL = 5'h00,
	parameter logic [5:0] HI_SEL = 6'h00
) (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic CLK_EN,
	input wire ioss_pkg::ioss_buses_s BUSES,
	input wire ioss_pkg::ioss_lanes_s LANES,
	input wire logic SEL_VALID
);
	localparam bit Q6 = (LO_SEL == 5'h0b) && (HI_SEL == 6'h2b);
	localparam bit C16 = (LO_SEL == 5'h12) && (HI_SEL == 6'h32);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	// An enabled edge takes the buses; lanes show them one edge later.
	sequence s_q6; CLK_EN && Q6; endsequence
	sequence s_c16; CLK_EN && C16; endsequence
	property p_q6_lo; s_q6 |=> LANES.a[7] == {10'h000, $past(BUSES.a_lo[47:42])}; endproperty
	a_q6_lo: assert property (p_q6_lo) else $error("quad low lane wrong");
	property p_q6_hi; s_q6 |=> LANES.b[15] == {10'h000, $past(BUSES.b_hi[47:42])}; endproperty
	a_q6_hi: assert property (p_q6_hi) else $error("quad high lane wrong");
	property p_q6_used; s_q6 ##1 s_q6 |-> LANES.used == 16'hffff; endproperty
	a_q6_used: assert property (p_q6_used) else $error("quad lanes unused");
	property p_c16_lo; s_c16 |=> LANES.b[1] == $past(BUSES.b_lo[31:16]); endproperty
	a_c16_lo: assert property (p_c16_lo) else $error("compact low lane wrong");
	property p_c16_hi; s_c16 |=> LANES.a[3] == $past(BUSES.a_hi[31:16]); endproperty
	a_c16_hi: assert property (p_c16_hi) else $error("compact high lane wrong");
	property p_c16_idle; s_c16 |=> LANES.used == 16'h000f && LANES.a[15:4] == '0; endproperty
	a_c16_idle: assert property (p_c16_idle) else $error("compact extra lanes");
	property p_hold; !CLK_EN |=> $stable(LANES); endproperty
	a_hold: assert property (p_hold) else $error("lanes moved while frozen");
	property p_valid; CLK_EN |=> SEL_VALID; endproperty
	a_valid: assert property (p_valid) else $error("known codes not valid");
endmodule

// ### verification/ioss_slice_select_tb.sv
// Purpose: Self-checking bench for the slice selector.
// Assumes: The fabric model zeroes unused bus bits.
// Notes: Two instances cover the six-bit quad and sixteen-bit compact codes.
`timescale 1ns/1ps
module ioss_slice_select_tb;
	logic CLK = 1'b0;
	logic RESET_N = 1'b0;
	logic CLK_EN = 1'b0;
	int n_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	ioss_pkg::ioss_buses_s bq, bc, s;
	ioss_pkg::ioss_lanes_s lq, lc, keep;
	logic [15:0][15:0] ea, eb;
	logic vq, vc;
	// Fifty megahertz clock.
	always #10 CLK = ~CLK;
	// The quad fabric keeps its default layout width of 48 bits; both selector pairs match their formats.
	ioss_fabric_model fab_q (.CLK(CLK), .BUSES(bq));
	ioss_fabric_model #(.USED_W(32)) fab_c (.CLK(CLK), .BUSES(bc));
	ioss_slice_select #(.LO_SEL(5'h0b), .HI_SEL(6'h2b)) dut_u (.CLK(CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN),
		.BUSES(bq), .LANES(lq), .SEL_VALID(vq));
	ioss_slice_select #(.LO_SEL(5'h12), .HI_SEL(6'h32)) dut_c (.CLK(CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN),
		.BUSES(bc), .LANES(lc), .SEL_VALID(vc));
	task automatic chk(input string nm, input logic [255:0] seen, input logic [255:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic t_quad();
		repeat (4) begin
			@(negedge CLK);
			s = bq;
			@(negedge CLK);
			for (int i = 0; i < 8; i++) begin
				ea[i] = {10'h000, s.a_lo[6*i+:6]};
				eb[i] = {10'h000, s.b_lo[6*i+:6]};
				ea[i+8] = {10'h000, s.a_hi[6*i+:6]};
				eb[i+8] = {10'h000, s.b_hi[6*i+:6]};
			end
			chk("quad a", lq.a, ea);
			chk("quad b", lq.b, eb);
			chk("quad used", lq.used, 256'hffff);
			chk("quad valid", vq, 256'h1);
		end
	endtask
	task automatic t_compact();
		repeat (4) begin
			@(negedge CLK);
			s = bc;
			@(negedge CLK);
			ea = '0;
			eb = '0;
			for (int i = 0; i < 2; i++) begin
				ea[i] = s.a_lo[16*i+:16];
				eb[i] = s.b_lo[16*i+:16];
				ea[i+2] = s.a_hi[16*i+:16];
				eb[i+2] = s.b_hi[16*i+:16];
			end
			chk("compact a", lc.a, ea);
			chk("compact b", lc.b, eb);
			chk("compact valid", vc, 256'h1);
		end
	endtask
	// Buses keep moving while the enable is low, so a leak into the quad instance's a lanes shows.
	task automatic t_hold();
		@(posedge CLK);
		CLK_EN <= 1'b0;
		@(negedge CLK);
		keep = lq;
		repeat (3) @(negedge CLK);
		chk("hold a", lq.a, keep.a);
		@(posedge CLK);
		CLK_EN <= 1'b1;
	endtask
	task automatic tally_and_finish();
		$display("mismatches %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Cycle ceiling well above the few dozen cycles the run needs.
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 300) begin
			n_errors++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (6) @(posedge CLK);
		RESET_N <= 1'b1;
		CLK_EN <= 1'b1;
		t_quad();
		t_compact();
		t_hold();
		t_quad();
		tally_and_finish();
	end
endmodule
bind ioss_slice_select ioss_slice_select_props #(.LO_SEL(LO_SEL), .HI_SEL(HI_SEL)) chk_u (.CLK(CLK),
	.RESET_N(RESET_N), .CLK_EN(CLK_EN), .BUSES(BUSES), .LANES(LANES), .SEL_VALID(SEL_VALID));
